//--- src/tx_fifo_info_power_mgmt_regs.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Bits 23-16 show status words used
// - Bits 15-0 show free data bytes
// - Power control register readable in power save
// - Writes ignored until first read after wake
// - Power state field selects mode, 11 ignored
// - Probe register write wakes device from power save
// - Transceiver reset held 100us, then self-clears
// - Reset bit writes ignored while it is high
// - LAN wake raises interrupt, gated output
// - Energy wake raises interrupt, gated output
// - Buffer kind: open-drain active low or push-pull
// - Indication style: 50ms pulse or static level
// - Output enable gates pin only, not interrupt
// - Ready reads one only once stabilised
module tx_fifo_info_power_mgmt_regs import pwr_regs_pkg::*; #(
  parameter int TRANSCEIVER_SOFT_RESET_LEN = TRANSCEIVER_SOFT_RESET_CYCLES,
  parameter int WAKE_PULSE_LEN = WAKE_PULSE_CYCLES,
  parameter int STABILISE_LEN = STABILISE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire reg_bus_t bus,
  output logic [31:0] rdData,
  input wire logic [7:0] txStatusWordsUsed,
  input wire logic [15:0] txDataBytesFree,
  input wire logic lanWakeEvent,
  input wire logic energyWakeEvent,
  output power_state_t powerStateSelect,
  output logic transceiverSoftReset,
  output logic wakePinOut,
  output logic wakePinOe,
  output logic deviceReady,
  output logic wakeInterrupt,
  output logic irq
);

  if (STABILISE_LEN < 1 || TRANSCEIVER_SOFT_RESET_LEN < 1 || WAKE_PULSE_LEN < 1) begin : g_chk
    $error("timing lengths must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] statusWordsUsed;
  logic [15:0] dataBytesFree;
  logic readSeen;
  logic bootKick;
  wake_ctrl_t ctrl;
  logic [1:0] wakeStatus;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic phyBusy;
  logic phyDone;
  logic pulseBusy;
  logic stabBusy;
  logic stabDone;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Writes other than the wake probe need a read first and a ready device
  wire acceptWr = bus.wr && readSeen && deviceReady;
  wire hitTx = (bus.addr == OFF_TX_FIFO_LEVEL_INFO);
  wire hitPs = (bus.addr == OFF_POWER_STATE_CONTROL);
  wire hitProbe = (bus.addr == OFF_WAKE_PROBE);
  wire hitStat = (bus.addr == OFF_IRQ_STATUS);
  wire hitMask = (bus.addr == OFF_IRQ_MASK);
  wire psWr = acceptWr && hitPs;
  wire inSaving = (powerStateSelect != PS_NORMAL);
  // Any data written to the probe wakes a sleeping device
  wire probeWake = bus.wr && hitProbe && inSaving;
  wire [1:0] selWr = bus.wdata[PS_SEL_LSB +: 2];
  wire enterSaving = psWr && !inSaving && (selWr == PS_LAN_DETECT || selWr == PS_ENERGY_DETECT);
  wire phyStart = psWr && bus.wdata[PS_TRANSCEIVER_SOFT_RESET] && !phyBusy;
  wire lanEvt = lanWakeEvent && ctrl.lanWakeEnable;
  wire energyEvt = energyWakeEvent && ctrl.energyWakeEnable;
  wire [1:0] wsSet = {lanEvt, energyEvt};
  wire [1:0] wsClr = psWr ? bus.wdata[PS_WS_LAN -: 2] : 2'h0;
  wire [IRQ_W-1:0] irqSet;
  wire [IRQ_W-1:0] irqClr = (acceptWr && hitStat) ? bus.wdata[IRQ_W-1:0] : '0;

  assign irqSet[IRQ_LAN] = lanEvt;
  assign irqSet[IRQ_ENERGY] = energyEvt;
  assign irqSet[IRQ_PHY_DONE] = phyDone;
  assign irqSet[IRQ_READY] = stabDone;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  cycle_timer #(.W(24), .LENGTH(TRANSCEIVER_SOFT_RESET_LEN)) u_phy_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(phyStart),
    .busy(phyBusy),
    .done(phyDone)
  );

  cycle_timer #(.W(24), .LENGTH(WAKE_PULSE_LEN)) u_pulse_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start((lanEvt || energyEvt) && ctrl.wakeIndicationStyle),
    .busy(pulseBusy),
    .done()
  );

  // Stabilisation after reset release and after every wake
  cycle_timer #(.W(24), .LENGTH(STABILISE_LEN)) u_stab_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(bootKick || probeWake),
    .busy(stabBusy),
    .done(stabDone)
  );

  assign transceiverSoftReset = phyBusy;

  // ----------------------------------------------------------------
  // Sampled FIFO levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      statusWordsUsed <= RST_STATUS_WORDS_USED;
      dataBytesFree <= RST_DATA_BYTES_FREE;
    end else begin
      statusWordsUsed <= txStatusWordsUsed;
      dataBytesFree <= txDataBytesFree;
    end
  end

  // ----------------------------------------------------------------
  // Power state, ready and read gate
  // ----------------------------------------------------------------
  // Ready drops on entering power save and returns after stabilising
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerStateSelect <= PS_NORMAL;
      deviceReady <= 1'b0;
      bootKick <= 1'b1;
      readSeen <= 1'b0;
    end else begin
      bootKick <= 1'b0;
      if (probeWake) begin
        powerStateSelect <= PS_NORMAL;
      end else if (enterSaving) begin
        powerStateSelect <= power_state_t'(selWr);
      end
      if (enterSaving || probeWake) begin
        deviceReady <= 1'b0;
      end else if (stabDone) begin
        deviceReady <= 1'b1;
      end
      if (probeWake) begin
        readSeen <= 1'b0;
      end else if (bus.rd) begin
        readSeen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake control bits and sticky wake status
  // ----------------------------------------------------------------
  // Status set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      wakeStatus <= 2'h0;
    end else begin
      if (psWr) begin
        ctrl.lanWakeEnable <= bus.wdata[PS_LAN_EN];
        ctrl.energyWakeEnable <= bus.wdata[PS_ENERGY_EN];
        ctrl.wakeOutputBufferKind <= bus.wdata[PS_BUF_KIND];
        ctrl.wakeIndicationStyle <= bus.wdata[PS_IND_STYLE];
        ctrl.wakeOutputPolarity <= bus.wdata[PS_POLARITY];
        ctrl.wakeOutputEnable <= bus.wdata[PS_OUT_EN];
      end
      wakeStatus <= (wakeStatus & ~wsClr) | wsSet;
    end
  end

  assign wakeInterrupt = |wakeStatus;

  // ----------------------------------------------------------------
  // Wake pin
  // ----------------------------------------------------------------
  wire wakeActive = ctrl.wakeOutputEnable && (ctrl.wakeIndicationStyle ? pulseBusy : wakeInterrupt);
  wire nextWakeOe = ctrl.wakeOutputBufferKind ? 1'b1 : wakeActive;
  wire nextWakeOut = ctrl.wakeOutputBufferKind && (ctrl.wakeOutputPolarity ? wakeActive : !wakeActive);

  // Registered so the pin never glitches on decode changes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wakePinOe <= 1'b0;
      wakePinOut <= 1'b0;
    end else begin
      wakePinOe <= nextWakeOe;
      wakePinOut <= nextWakeOut;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= '0;
      irqMask <= '0;
    end else begin
      irqStatus <= (irqStatus & ~irqClr) | irqSet;
      if (acceptWr && hitMask) begin
        irqMask <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] txInfoWord = {8'h00, statusWordsUsed, dataBytesFree};
  wire [31:0] psWord;
  // Reserved positions stay zero
  assign psWord = {18'h0, powerStateSelect, 1'b0, phyBusy, ctrl.lanWakeEnable, ctrl.energyWakeEnable,
                   1'b0, ctrl.wakeOutputBufferKind, wakeStatus, ctrl.wakeIndicationStyle,
                   ctrl.wakeOutputPolarity, ctrl.wakeOutputEnable, deviceReady};
  wire [31:0] readMux = hitTx ? txInfoWord :
                        hitPs ? psWord :
                        hitProbe ? WAKE_PROBE_PATTERN :
                        hitStat ? {{(32-IRQ_W){1'b0}}, irqStatus} :
                        hitMask ? {{(32-IRQ_W){1'b0}}, irqMask} : 32'h00000000;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= bus.rd ? readMux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int WAKE_BOUND = 1000;
  logic [23:0] phyHeld;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phyHeld <= '0;
    end else begin
      phyHeld <= phyBusy ? phyHeld + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_tx_read;
    bus.rd && hitTx;
  endsequence

  sequence s_wake_write;
    bus.wr && hitProbe && inSaving;
  endsequence

  a_tx_info_read: assert property (s_tx_read |=> rdData == {8'h00, $past(statusWordsUsed), $past(dataBytesFree)})
    else $error("transmit FIFO info read wrong");

  a_reserved_zero: assert property (bus.rd && hitPs |=> rdData[31:14] == '0 && rdData[11] == 1'b0 && rdData[7] == 1'b0)
    else $error("reserved bits not zero");

  a_power_read_live: assert property (bus.rd && hitPs && inSaving |=> rdData[PS_SEL_LSB +: 2] != 2'h0)
    else $error("power state not readable in power save");

  a_write_needs_read: assert property (bus.wr && hitMask && !readSeen |=> irqMask == $past(irqMask))
    else $error("write accepted before first read");

  a_mode_reserved: assert property (bus.wr && hitPs && selWr == PS_RESERVED |=> powerStateSelect != PS_RESERVED)
    else $error("reserved power state entered");

  a_probe_wake: assert property (s_wake_write |=> powerStateSelect == PS_NORMAL && !deviceReady)
    else $error("probe write did not wake device");

  a_ready_return: assert property (s_wake_write |-> ##[1:WAKE_BOUND] deviceReady)
    else $error("ready did not return after wake");

  a_ready_low_saving: assert property (inSaving |-> !deviceReady)
    else $error("ready set during power save");

  // The held count of the last busy cycle is what the falling edge samples
  a_phy_reset_len: assert property ($fell(transceiverSoftReset) |-> phyHeld == 24'(TRANSCEIVER_SOFT_RESET_LEN))
    else $error("transceiver reset length wrong");

  a_wake_irq: assert property (lanEvt || energyEvt |=> wakeInterrupt)
    else $error("wake interrupt not raised");

  // Pin enable is registered, so it follows the control bits one cycle later
  a_pin_gated: assert property (!ctrl.wakeOutputEnable && !ctrl.wakeOutputBufferKind |=> !wakePinOe)
    else $error("wake pin driven while disabled");

  a_open_drain_low: assert property (!$past(ctrl.wakeOutputBufferKind) |-> !wakePinOut)
    else $error("open drain pin driven high");

  a_pulse_style: assert property (ctrl.wakeOutputEnable && ctrl.wakeIndicationStyle && !pulseBusy
                                  && (lanEvt || energyEvt) |=> pulseBusy [*8])
    else $error("wake pulse too short");

endmodule // tx_fifo_info_power_mgmt_regs

//--- src/pwr_regs_pkg.sv
package pwr_regs_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_TX_FIFO_LEVEL_INFO = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_POWER_STATE_CONTROL = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_WAKE_PROBE = 8'h90;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h94;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h98;

  // Arbitrary pattern returned by the wake probe register
  localparam logic [31:0] WAKE_PROBE_PATTERN = 32'h0f1e2d3c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TXINF_USED_LSB = 16;
  localparam int PS_SEL_LSB = 12;
  localparam int PS_TRANSCEIVER_SOFT_RESET = 10;
  localparam int PS_LAN_EN = 9;
  localparam int PS_ENERGY_EN = 8;
  localparam int PS_BUF_KIND = 6;
  localparam int PS_WS_LAN = 5;
  localparam int PS_WS_ENERGY = 4;
  localparam int PS_IND_STYLE = 3;
  localparam int PS_POLARITY = 2;
  localparam int PS_OUT_EN = 1;
  localparam int PS_READY = 0;

  // Interrupt status / mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_LAN = 0;
  localparam int IRQ_ENERGY = 1;
  localparam int IRQ_PHY_DONE = 2;
  localparam int IRQ_READY = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS_WORDS_USED = 8'h00;
  localparam logic [15:0] RST_DATA_BYTES_FREE = 16'h1200;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TRANSCEIVER_SOFT_RESET_TIME_US = 100;
  localparam int WAKE_PULSE_TIME_MS = 50;
  localparam int STABILISE_TIME_NS = 2000;
  // Least time: round up, except the wake pulse count, which is truncated
  localparam int TRANSCEIVER_SOFT_RESET_CYCLES = (TRANSCEIVER_SOFT_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_CYCLES = (WAKE_PULSE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int STABILISE_CYCLES = (STABILISE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_NORMAL = 2'h0,
    PS_LAN_DETECT = 2'h1,
    PS_ENERGY_DETECT = 2'h2,
    PS_RESERVED = 2'h3
  } power_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;

  typedef struct packed {
    logic lanWakeEnable;
    logic energyWakeEnable;
    logic wakeOutputBufferKind;
    logic wakeIndicationStyle;
    logic wakeOutputPolarity;
    logic wakeOutputEnable;
  } wake_ctrl_t;

endpackage

//--- src/cycle_timer.sv
`timescale 1ns/1ps
// One-shot down counter: busy for exactly LENGTH cycles after start
module cycle_timer #(
  parameter int W = 24,
  parameter int LENGTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  if (LENGTH < 1 || LENGTH >= (2 ** W)) begin : g_chk
    $error("cycle_timer LENGTH does not fit W");
  end

  localparam logic [W-1:0] LOAD = W'(LENGTH);
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] count;

  // Start is ignored while running, so a held request cannot stretch it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (start && count == '0) begin
      count <= LOAD;
    end else if (count != '0) begin
      count <= count - ONE;
    end
  end

  assign busy = (count != '0);
  assign done = (count == ONE);

endmodule // cycle_timer

//--- tb/host_bus_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: bus master and transmit FIFO occupancy source
// ------------------------------------------------------------
module host_bus_model import pwr_regs_pkg::*; (
  input wire logic clk_sys,
  input wire logic [31:0] rdData,
  input wire logic deviceReady,
  output reg_bus_t bus,
  output logic [7:0] usedWords,
  output logic [15:0] freeBytes
);
  // Idle bus and empty FIFOs at time zero
  initial begin
    bus = '0;
    usedWords = RST_STATUS_WORDS_USED;
    freeBytes = RST_DATA_BYTES_FREE;
  end

  // One-cycle write; released lines show inverted data so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (!deviceReady && a != OFF_WAKE_PROBE) return;
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '{addr: ~a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = rdData;
  endtask

  // Queue frame bytes only within the reported free space
  task automatic push(input int n, input logic [7:0] words);
    @(posedge clk_sys);
    if (n <= int'(freeBytes)) begin
      freeBytes <= freeBytes - 16'(n);
      usedWords <= words;
    end
  endtask
endmodule // host_bus_model

//--- tb/test_tx_fifo_info_power_mgmt_regs.sv
`timescale 1ns/1ps
module test_tx_fifo_info_power_mgmt_regs import pwr_regs_pkg::*;;
  localparam int PHY_LEN = 20;
  localparam int PULSE_LEN = 30;
  logic clk_sys, rst_n, lanWakeEvent, energyWakeEvent;
  reg_bus_t bus;
  logic [31:0] rdData;
  logic [7:0] usedWords;
  logic [15:0] freeBytes;
  power_state_t powerStateSelect;
  logic transceiverSoftReset, wakePinOut, wakePinOe, deviceReady, wakeInterrupt, irq;
  int errTotal = 0;
  int testsRun = 0;
  int n;

  tx_fifo_info_power_mgmt_regs #(.TRANSCEIVER_SOFT_RESET_LEN(PHY_LEN), .WAKE_PULSE_LEN(PULSE_LEN), .STABILISE_LEN(10)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdData(rdData), .txStatusWordsUsed(usedWords),
    .txDataBytesFree(freeBytes), .lanWakeEvent(lanWakeEvent), .energyWakeEvent(energyWakeEvent),
    .powerStateSelect(powerStateSelect), .transceiverSoftReset(transceiverSoftReset), .wakePinOut(wakePinOut),
    .wakePinOe(wakePinOe), .deviceReady(deviceReady), .wakeInterrupt(wakeInterrupt), .irq(irq));

  host_bus_model i_host (.clk_sys(clk_sys), .rdData(rdData), .deviceReady(deviceReady), .bus(bus),
    .usedWords(usedWords), .freeBytes(freeBytes));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    i_host.rd(a, d);
    chk(what, e, d & m);
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait; a timeout is a failure, not a hang
  task automatic wait_ready;
    int k;
    for (k = 0; k < 100 && deviceReady !== 1'b1; k++) @(posedge clk_sys);
    chk("ready within bound", 1, deviceReady);
    if (deviceReady !== 1'b1) close_out;
  endtask

  // Count cycles a level stays high: 0 watches transceiver reset, 1 the pin enable
  task automatic count_high(input int w, output int c);
    int k;
    c = 0;
    // Settle first so a level launched at this very edge is seen
    #1;
    for (k = 0; k < 50 && (w ? wakePinOe : transceiverSoftReset) !== 1'b1; k++) @(posedge clk_sys) #1;
    while ((w ? wakePinOe : transceiverSoftReset) === 1'b1 && c < 200) begin
      c++;
      @(posedge clk_sys) #1;
    end
  endtask

  task automatic pulse(input logic lan, input logic energy);
    @(posedge clk_sys);
    lanWakeEvent <= lan;
    energyWakeEvent <= energy;
    @(posedge clk_sys);
    lanWakeEvent <= 1'b0;
    energyWakeEvent <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_fifo_info;
    expect_rd("fifo info reset", OFF_TX_FIFO_LEVEL_INFO, '1, 32'h00001200);
    i_host.push(32'h0a00, 8'h5a);
    expect_rd("fifo info level", OFF_TX_FIFO_LEVEL_INFO, '1, 32'h005a0800);
    $display("test fifo_info done");
  endtask

  // Reserved bits and an unmapped address must not stick
  task automatic t_reserved;
    wait_ready;
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'hffffca80);
    expect_rd("ctrl reserved", OFF_POWER_STATE_CONTROL, '1, 32'h00000201);
    i_host.wr(8'ha0, '1);
    expect_rd("unmapped", 8'ha0, '1, 32'h0);
    expect_rd("ctrl after unmapped", OFF_POWER_STATE_CONTROL, '1, 32'h00000201);
    $display("test reserved done");
  endtask

  // A second request mid-reset must not stretch the reset
  task automatic t_phy_reset;
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0400);
    fork
      count_high(0, n);
      begin
        repeat (5) @(posedge clk_sys);
        i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0400);
      end
    join
    chk("phy reset length", PHY_LEN, n);
    expect_rd("phy bit cleared", OFF_POWER_STATE_CONTROL, 32'h0400, 32'h0);
    $display("test phy_reset done");
  endtask

  task automatic t_wake_static;
    i_host.wr(OFF_IRQ_STATUS, 32'hf);
    i_host.wr(OFF_IRQ_MASK, 32'h1);
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0246);
    pulse(1'b1, 1'b1);
    chk("wake interrupt", 1, wakeInterrupt);
    chk("irq unmasked", 1, irq);
    chk("pin oe push-pull", 1, wakePinOe);
    chk("pin active high", 1, wakePinOut);
    expect_rd("wake status", OFF_POWER_STATE_CONTROL, 32'h30, 32'h20);
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0244);
    i_host.wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_sys) #1;
    chk("pin gated", 0, wakePinOut);
    chk("interrupt kept", 1, wakeInterrupt);
    chk("irq masked", 0, irq);
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0264);
    repeat (2) @(posedge clk_sys) #1;
    chk("interrupt cleared", 0, wakeInterrupt);
    $display("test wake_static done");
  endtask

  // Open-drain pulse: polarity set yet the pin must pull low
  task automatic t_wake_pulse;
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h010e);
    @(posedge clk_sys);
    energyWakeEvent <= 1'b1;
    @(posedge clk_sys);
    energyWakeEvent <= 1'b0;
    fork
      count_high(1, n);
      begin
        repeat (4) @(posedge clk_sys) #2;
        chk("open-drain level", 0, wakePinOut);
      end
    join
    chk("pulse length", PULSE_LEN, n);
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h011e);
    $display("test wake_pulse done");
  endtask

  task automatic t_power_state;
    i_host.wr(OFF_POWER_STATE_CONTROL, 32'h3000);
    expect_rd("reserved state", OFF_POWER_STATE_CONTROL, 32'h3000, 32'h0);
    for (int s = 1; s < 3; s++) begin
      i_host.wr(OFF_POWER_STATE_CONTROL, 32'(s) << 12);
      @(posedge clk_sys) #1;
      chk("state select", 32'(s), 32'(powerStateSelect));
      expect_rd("ctrl in power save", OFF_POWER_STATE_CONTROL, 32'h3000, 32'(s) << 12);
      i_host.wr(OFF_WAKE_PROBE, 32'h0);
      repeat (2) @(posedge clk_sys) #1;
      chk("woken state", 0, 32'(powerStateSelect));
      chk("ready dropped", 0, deviceReady);
      wait_ready;
      i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0200);
      i_host.wr(OFF_IRQ_MASK, 32'hf);
      expect_rd("write before read", OFF_POWER_STATE_CONTROL, 32'h0200, 32'h0);
      expect_rd("mask before read", OFF_IRQ_MASK, '1, 32'h0);
      i_host.wr(OFF_POWER_STATE_CONTROL, 32'h0200);
      expect_rd("write after read", OFF_POWER_STATE_CONTROL, 32'h0200, 32'h0200);
    end
    expect_rd("probe pattern", OFF_WAKE_PROBE, '1, WAKE_PROBE_PATTERN);
    $display("test power_state done");
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'b0;
    lanWakeEvent = 1'b0;
    energyWakeEvent = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_fifo_info;
    t_reserved;
    t_phy_reset;
    t_wake_static;
    t_wake_pulse;
    t_power_state;
    close_out;
  end

  initial begin
    #400000;
    errTotal++;
    close_out;
  end
endmodule // test_tx_fifo_info_power_mgmt_regs
